//--- core/line_power_ctrl.v
// Power-mode control and missing-signal detector of a dual line transceiver
// Functional notes
// - Force-shutdown low forces shutdown; transmitters high-Z, receivers keep working.
// - Force-active high with force-shutdown high keeps transmitters on, timer ignored.
// - Automatic mode shuts transmitters and supply after 30 s of no input activity.
// - Every receiver or transmitter input edge restarts the inactivity time.
// - Automatic shutdown ends on any transition at receiver or transmitter inputs.
// - Transmitters become active 25 us after leaving shutdown.
// - Missing-signal output goes low after 90 us without valid levels on all receivers.
// - Missing-signal output high while receive activity valid, in every mode.
// - Receivers always active; each output is the inverse of its line input.
// - Enabled transmitters drive the inverse of their logic input.
// - Pump runs in bursts: on while rail below 5.5 V, off above.
// - Any shutdown stops pumps and floats transmitter outputs.
// - Missing signal only when both receivers sit inside +-0.3 V for 90 us.
// - Inactivity shutdown interval lies between 15 and 60 s, nominally 30.
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "line_power_defs.vh"

module line_power_ctrl #(
  parameter        NCH         = 2,
  parameter        ADDR_W      = 12,
  parameter [35:0] IDLE_CYCLES = `IDLE_CYC,
  parameter [35:0] WAKE_CYCLES = `WAKE_CYC,
  parameter [35:0] MISS_CYCLES = `MISS_CYC
) (
  input  wire              pclk,
  input  wire              presetn,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [ADDR_W-1:0] paddr,
  input  wire [31:0]       pwdata,
  output wire              pready,
  output reg  [31:0]       prdata,
  output wire              pslverr,
  output wire              irq,
  input  wire              force_shutdown_n,
  input  wire              force_active,
  input  wire [NCH-1:0]    tx_in,
  input  wire [NCH-1:0]    rx_line,
  input  wire [NCH-1:0]    rx_level_valid,
  input  wire              rail_pos_low,
  input  wire              rail_neg_low,
  output wire [NCH-1:0]    rx_out,
  output wire [NCH-1:0]    tx_line_out,
  output wire [NCH-1:0]    tx_line_oe,
  output wire              missing_signal_n,
  output wire              pump_pos_en,
  output wire              pump_neg_en,
  output wire              supply_on
);

  // ----------------------------------------------------------------
  // Operating modes
  // ----------------------------------------------------------------
  localparam [1:0] MODE_ACTIVE     = 2'h0;
  localparam [1:0] MODE_WAKING     = 2'h1;
  localparam [1:0] MODE_AUTO_OFF   = 2'h2;
  localparam [1:0] MODE_FORCED_OFF = 2'h3;

  localparam SW = 3 * NCH + 4;

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  wire [SW-1:0] pins_s;
  wire [NCH-1:0] tx_s;
  wire [NCH-1:0] rx_s;
  wire [NCH-1:0] valid_s;
  wire          fshdn_n_s;
  wire          fact_s;
  wire          pos_low_s;
  wire          neg_low_s;

  // Force-shutdown line resets high so reset lands in automatic active mode
  pin_sync #(
    .WIDTH   (SW),
    .RST_VAL ({{(SW-4){1'b0}}, 4'h1})
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     ({tx_in, rx_line, rx_level_valid, rail_neg_low, rail_pos_low,
               force_active, force_shutdown_n}),
    .sync    (pins_s)
  );

  assign fshdn_n_s = pins_s[0];
  assign fact_s    = pins_s[1];
  assign pos_low_s = pins_s[2];
  assign neg_low_s = pins_s[3];
  assign valid_s   = pins_s[NCH+3:4];
  assign rx_s      = pins_s[2*NCH+3:NCH+4];
  assign tx_s      = pins_s[3*NCH+3:2*NCH+4];

  // ----------------------------------------------------------------
  // Activity edge detection
  // ----------------------------------------------------------------
  reg  [NCH-1:0] rx_prev_q;
  reg  [NCH-1:0] tx_prev_q;
  wire           activity;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_prev_q <= {NCH{1'b0}};
      tx_prev_q <= {NCH{1'b0}};
    end else begin
      rx_prev_q <= rx_s;
      tx_prev_q <= tx_s;
    end
  end

  assign activity = |((rx_s ^ rx_prev_q) | (tx_s ^ tx_prev_q));

  // ----------------------------------------------------------------
  // Mode state machine
  // ----------------------------------------------------------------
  reg  [1:0]  mode_q;
  reg  [1:0]  mode_d;
  reg  [35:0] idle_cnt_q;
  reg  [35:0] idle_cnt_d;
  reg  [15:0] wake_cnt_q;
  reg  [15:0] wake_cnt_d;
  wire        idle_done;
  wire        wake_done;

  assign idle_done = (idle_cnt_q == IDLE_CYCLES - 36'd1);
  assign wake_done = (wake_cnt_q == WAKE_CYCLES[15:0] - 16'd1);

  always @* begin
    mode_d     = mode_q;
    idle_cnt_d = 36'd0;
    wake_cnt_d = 16'd0;
    if (!fshdn_n_s) begin
      mode_d = MODE_FORCED_OFF;
    end else begin
      case (mode_q)
        MODE_ACTIVE: begin
          if (!fact_s && !activity) begin
            if (idle_done) begin
              mode_d = MODE_AUTO_OFF;
            end else begin
              idle_cnt_d = idle_cnt_q + 36'd1;
            end
          end
        end
        MODE_WAKING: begin
          if (wake_done) begin
            mode_d = MODE_ACTIVE;
          end else begin
            wake_cnt_d = wake_cnt_q + 16'd1;
          end
        end
        MODE_AUTO_OFF: begin
          if (fact_s || activity) begin
            mode_d = MODE_WAKING;
          end
        end
        MODE_FORCED_OFF: begin
          mode_d = MODE_WAKING;
        end
        default: begin
          mode_d = MODE_ACTIVE;
        end
      endcase
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q     <= MODE_ACTIVE;
      idle_cnt_q <= 36'd0;
      wake_cnt_q <= 16'd0;
    end else begin
      mode_q     <= mode_d;
      idle_cnt_q <= idle_cnt_d;
      wake_cnt_q <= wake_cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // Missing-signal detector
  // ----------------------------------------------------------------
  reg  [35:0] miss_cnt_q;
  reg         missing_n_q;
  wire        any_valid;

  assign any_valid = |valid_s;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      miss_cnt_q  <= 36'd0;
      missing_n_q <= 1'b1;
    end else if (any_valid) begin
      miss_cnt_q  <= 36'd0;
      missing_n_q <= 1'b1;
    end else if (miss_cnt_q == MISS_CYCLES - 36'd1) begin
      missing_n_q <= 1'b0;
    end else begin
      miss_cnt_q  <= miss_cnt_q + 36'd1;
    end
  end

  // ----------------------------------------------------------------
  // Line datapath and pump control
  // ----------------------------------------------------------------
  reg  [NCH-1:0] rx_out_q;
  reg  [NCH-1:0] tx_out_q;
  reg            tx_en_q;
  reg            pump_pos_q;
  reg            pump_neg_q;
  reg            supply_q;
  wire           powered;

  assign powered = (mode_d == MODE_ACTIVE) || (mode_d == MODE_WAKING);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_out_q   <= {NCH{1'b1}};
      tx_out_q   <= {NCH{1'b1}};
      tx_en_q    <= 1'b0;
      pump_pos_q <= 1'b0;
      pump_neg_q <= 1'b0;
      supply_q   <= 1'b1;
    end else begin
      rx_out_q   <= ~rx_s;
      tx_out_q   <= ~tx_s;
      tx_en_q    <= (mode_d == MODE_ACTIVE);
      pump_pos_q <= powered & pos_low_s;
      pump_neg_q <= powered & neg_low_s;
      supply_q   <= powered;
    end
  end

  assign rx_out           = rx_out_q;
  assign tx_line_out      = tx_out_q;
  assign tx_line_oe       = {NCH{tx_en_q}};
  assign missing_signal_n = missing_n_q;
  assign pump_pos_en      = pump_pos_q;
  assign pump_neg_en      = pump_neg_q;
  assign supply_on        = supply_q;

  // ----------------------------------------------------------------
  // Interrupt events
  // ----------------------------------------------------------------
  reg  [`IRQ_W-1:0] irq_stat_q;
  reg  [`IRQ_W-1:0] irq_mask_q;
  reg               tx_en_prev_q;
  reg               missing_prev_q;
  reg  [1:0]        mode_prev_q;
  wire [`IRQ_W-1:0] irq_set;
  wire [`IRQ_W-1:0] irq_clr;
  wire              wr_en;
  wire              rd_setup;
  wire [ADDR_W-1:0] addr;

  assign irq_set[`IRQ_AUTO_OFF] = (mode_q == MODE_AUTO_OFF) &&
                                  (mode_prev_q != MODE_AUTO_OFF);
  assign irq_set[`IRQ_TX_ON]    = tx_en_q & ~tx_en_prev_q;
  assign irq_set[`IRQ_LOST]     = ~missing_n_q & missing_prev_q;
  assign irq_set[`IRQ_RESTORED] = missing_n_q & ~missing_prev_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_en_prev_q   <= 1'b0;
      missing_prev_q <= 1'b1;
      mode_prev_q    <= MODE_ACTIVE;
    end else begin
      tx_en_prev_q   <= tx_en_q;
      missing_prev_q <= missing_n_q;
      mode_prev_q    <= mode_q;
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  assign addr     = paddr;
  assign pready   = 1'b1;
  assign wr_en    = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pslverr  = psel & penable &
                    (addr != `REG_STATUS) &&
                    (addr != `REG_IRQ_STATUS) &&
                    (addr != `REG_IRQ_MASK);
  assign irq_clr  = (wr_en && addr == `REG_IRQ_STATUS) ?
                    pwdata[`IRQ_W-1:0] : {`IRQ_W{1'b0}};
  assign irq      = |(irq_stat_q & irq_mask_q);

  // Set wins over a simultaneous write-one-to-clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= {`IRQ_W{1'b0}};
      irq_mask_q <= `IRQ_MASK_RST;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
      if (wr_en && addr == `REG_IRQ_MASK) begin
        irq_mask_q <= pwdata[`IRQ_W-1:0];
      end
    end
  end

  // Read data is captured in the setup cycle and stands through access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_setup) begin
      prdata <= 32'h00000000;
      case (addr)
        `REG_STATUS: begin
          prdata[`ST_MODE_MSB:`ST_MODE_LSB] <= mode_q;
          prdata[`ST_TX_EN]                 <= tx_en_q;
          prdata[`ST_MISSING_N]             <= missing_n_q;
          prdata[`ST_PUMP_POS]              <= pump_pos_q;
          prdata[`ST_PUMP_NEG]              <= pump_neg_q;
          prdata[`ST_FORCE_POWER_DOWN_N_INPUT_N]          <= fshdn_n_s;
          prdata[`ST_FORCE_ACT]             <= fact_s;
        end
        `REG_IRQ_STATUS: begin
          prdata[`IRQ_W-1:0] <= irq_stat_q;
        end
        `REG_IRQ_MASK: begin
          prdata[`IRQ_W-1:0] <= irq_mask_q;
        end
        default: begin
          prdata <= 32'h00000000;
        end
      endcase
    end
  end

endmodule // line_power_ctrl

`default_nettype wire

//--- core/line_power_defs.vh
// Constants for the line transceiver power-mode controller
`ifndef LINE_POWER_DEFS_VH
`define LINE_POWER_DEFS_VH

// ----------------------------------------------------------------
// Clock rate and timing
// ----------------------------------------------------------------
`define CLK_MHZ         36'd250
`define IDLE_SEC        36'd30
`define IDLE_CYC        (`IDLE_SEC * 36'd1000000 * `CLK_MHZ)
`define WAKE_US         36'd25
`define WAKE_CYC        (`WAKE_US * `CLK_MHZ)
`define MISS_US         36'd90
`define MISS_CYC        (`MISS_US * `CLK_MHZ)

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define REG_STATUS      12'h000
`define REG_IRQ_STATUS  12'h004
`define REG_IRQ_MASK    12'h008

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define ST_MODE_LSB     0
`define ST_MODE_MSB     1
`define ST_TX_EN        2
`define ST_MISSING_N    3
`define ST_PUMP_POS     4
`define ST_PUMP_NEG     5
`define ST_FORCE_POWER_DOWN_N_INPUT_N 6
`define ST_FORCE_ACT    7

// ----------------------------------------------------------------
// Interrupt bits and reset values
// ----------------------------------------------------------------
`define IRQ_W           4
`define IRQ_AUTO_OFF    0
`define IRQ_TX_ON       1
`define IRQ_LOST        2
`define IRQ_RESTORED    3
`define IRQ_MASK_RST    4'h0

`endif

//--- core/pin_sync.v
// Two-stage synchroniser for a vector of asynchronous pins
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter       WIDTH   = 1,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  input  wire             pclk,
  input  wire             presetn,
  input  wire [WIDTH-1:0] pin,
  output wire [WIDTH-1:0] sync
);

  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
    end
  end

  assign sync = sync_q;

endmodule // pin_sync

`default_nettype wire

//--- dv/line_power_ctrl_sva.sv
// Assertion checker for the line power-mode controller ports
`timescale 1ns/1ps
`default_nettype none
module line_power_ctrl_sva #(
  parameter [35:0] IDLE_CYCLES = 36'd200,
  parameter [35:0] WAKE_CYCLES = 36'd10,
  parameter [35:0] MISS_CYCLES = 36'd50
) (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       force_shutdown_n,
  input wire logic       force_active,
  input wire logic [1:0] tx_in,
  input wire logic [1:0] rx_line,
  input wire logic [1:0] rx_level_valid,
  input wire logic       rail_pos_low,
  input wire logic       rail_neg_low,
  input wire logic [1:0] rx_out,
  input wire logic [1:0] tx_line_out,
  input wire logic [1:0] tx_line_oe,
  input wire logic       missing_signal_n,
  input wire logic       pump_pos_en,
  input wire logic       pump_neg_en,
  input wire logic       supply_on
);
  localparam int WK_MAX = 40;
  logic [35:0] miss_q;
  logic [35:0] idle_q;
  logic [35:0] wake_q;
  logic        sup_q;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------
  // Duration counters
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      miss_q <= 36'h0;
      idle_q <= 36'h0;
      wake_q <= 36'h0;
      sup_q  <= 1'b1;
    end else begin
      miss_q <= (|rx_level_valid) ? 36'h0 : miss_q + 36'h1;
      idle_q <= ($changed({tx_in, rx_line, force_active, force_shutdown_n}) || force_active
                 || !force_shutdown_n) ? 36'h0 : idle_q + 36'h1;
      sup_q  <= supply_on;
      if (supply_on && !sup_q)
        wake_q <= 36'h1;
      else if (wake_q != 36'h0)
        wake_q <= (tx_line_oe != 2'b00) ? 36'h0 : wake_q + 36'h1;
    end
  end
  sequence s_held_off;
    (!force_shutdown_n)[*6];
  endsequence
  sequence s_held_on;
    (force_shutdown_n && force_active)[*8] ##0 (tx_line_oe == 2'b11);
  endsequence
  sequence s_line_edge;
    !supply_on && force_shutdown_n && !force_active && $changed({tx_in, rx_line});
  endsequence
  property p_force_off;
    s_held_off |-> tx_line_oe == 2'b00 && !supply_on && !pump_pos_en && !pump_neg_en;
  endproperty
  property p_force_on;
    s_held_on |=> tx_line_oe == 2'b11;
  endproperty
  property p_wake;
    (wake_q != 36'h0 && tx_line_oe != 2'b00) |->
      (wake_q + 36'd2 >= WAKE_CYCLES) && (wake_q <= WAKE_CYCLES + 36'd2);
  endproperty
  property p_auto_off;
    (idle_q > IDLE_CYCLES + WAKE_CYCLES + 36'd8) |-> tx_line_oe == 2'b00;
  endproperty
  property p_wake_edge;
    s_line_edge |-> ##[1:WK_MAX] (tx_line_oe == 2'b11);
  endproperty
  property p_miss_set;
    (miss_q >= MISS_CYCLES + 36'd4) |-> !missing_signal_n;
  endproperty
  property p_miss_hold;
    (|rx_level_valid)[*4] |-> missing_signal_n;
  endproperty
  property p_rx;
    $stable(rx_line)[*6] |-> rx_out == ~rx_line;
  endproperty
  property p_tx;
    $stable(tx_in)[*6] |-> tx_line_out == ~tx_in;
  endproperty
  property p_pump;
    ((supply_on && rail_pos_low)[*5] |-> pump_pos_en) and ((!rail_neg_low)[*4] |-> !pump_neg_en);
  endproperty
  a_force_off: assert property (p_force_off) else $error("outputs live in shutdown");
  a_force_on: assert property (p_force_on) else $error("forced-on drivers dropped");
  a_wake: assert property (p_wake) else $error("wake latency wrong");
  a_auto_off: assert property (p_auto_off) else $error("no idle shutdown");
  a_wake_edge: assert property (p_wake_edge) else $error("no wake on edge");
  a_miss_set: assert property (p_miss_set) else $error("missing flag late");
  a_miss_hold: assert property (p_miss_hold) else $error("missing flag with signal");
  a_rx: assert property (p_rx) else $error("receiver output wrong");
  a_tx: assert property (p_tx) else $error("transmitter output wrong");
  a_pump: assert property (p_pump) else $error("pump burst wrong");
endmodule // line_power_ctrl_sva
bind line_power_ctrl line_power_ctrl_sva #(
  .IDLE_CYCLES(IDLE_CYCLES), .WAKE_CYCLES(WAKE_CYCLES), .MISS_CYCLES(MISS_CYCLES)
) i_line_power_ctrl_sva (
  .pclk(pclk), .presetn(presetn), .force_shutdown_n(force_shutdown_n),
  .force_active(force_active), .tx_in(tx_in), .rx_line(rx_line),
  .rx_level_valid(rx_level_valid), .rail_pos_low(rail_pos_low), .rail_neg_low(rail_neg_low),
  .rx_out(rx_out), .tx_line_out(tx_line_out), .tx_line_oe(tx_line_oe),
  .missing_signal_n(missing_signal_n), .pump_pos_en(pump_pos_en),
  .pump_neg_en(pump_neg_en), .supply_on(supply_on)
);
`default_nettype wire

//--- dv/line_partner.sv
// Remote serial line partner driving the receive lines
`timescale 1ns/1ps
`default_nettype none
module line_partner (
  input  wire logic       pclk,
  input  wire logic       link_up,
  input  wire logic [1:0] data,
  output var  logic [1:0] rx_line,
  output var  logic [1:0] rx_level_valid
);
  initial begin
    rx_line        = 2'b00;
    rx_level_valid = 2'b00;
  end
  // A detached cable is pulled to ground: low and without valid level
  always @(posedge pclk) begin
    rx_line        <= link_up ? data : 2'b00;
    rx_level_valid <= link_up ? 2'b11 : 2'b00;
  end
endmodule // line_partner
`default_nettype wire

//--- dv/rs232_line_power_mode_control_bench.sv
// Self-checking bench for the line power-mode controller
`timescale 1ns/1ps
`default_nettype none
`include "line_power_defs.vh"
module rs232_line_power_mode_control_bench;
  localparam [35:0] IDLE = 36'd200;
  localparam [35:0] WAKE = 36'd10;
  localparam [35:0] MISS = 36'd50;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        force_shutdown_n = 1'b1;
  logic        force_active = 1'b0;
  logic [1:0]  tx_in = 2'b00;
  logic        rail_pos_low = 1'b0;
  logic        rail_neg_low = 1'b0;
  logic        link_up = 1'b1;
  logic [1:0]  data = 2'b00;
  logic [31:0] rd;
  logic        er;
  wire         pready, pslverr, irq, missing_signal_n, pump_pos_en, pump_neg_en, supply_on;
  wire  [31:0] prdata;
  wire  [1:0]  rx_line, rx_level_valid, rx_out, tx_line_out, tx_line_oe;
  int          err_total = 0;
  int          samples_checked = 0;
  always #2 pclk = ~pclk;
  line_power_ctrl #(.IDLE_CYCLES(IDLE), .WAKE_CYCLES(WAKE), .MISS_CYCLES(MISS)) i_line_power_ctrl (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .irq(irq), .force_shutdown_n(force_shutdown_n), .force_active(force_active),
    .tx_in(tx_in), .rx_line(rx_line), .rx_level_valid(rx_level_valid),
    .rail_pos_low(rail_pos_low), .rail_neg_low(rail_neg_low), .rx_out(rx_out),
    .tx_line_out(tx_line_out), .tx_line_oe(tx_line_oe), .missing_signal_n(missing_signal_n),
    .pump_pos_en(pump_pos_en), .pump_neg_en(pump_neg_en), .supply_on(supply_on));
  line_partner i_line_partner (.pclk(pclk), .link_up(link_up), .data(data),
    .rx_line(rx_line), .rx_level_valid(rx_level_valid));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [1:0] inv2(input logic [1:0] v);
    return ~v;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic print_verdict;
    $display("Checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge pclk);
    err_total++;
    print_verdict();
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h79b8));
    tick(8);
    presetn <= 1'b1;
    apb(1'b0, `REG_IRQ_MASK, 32'h0);
    chk("irq_mask_rst", {28'h0, `IRQ_MASK_RST}, rd);
    apb(1'b0, 12'h00c, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, er});
    repeat (24) begin
      data <= 2'($urandom);
      tx_in <= 2'($urandom);
      rail_pos_low <= 1'($urandom);
      rail_neg_low <= 1'($urandom);
      tick(6);
      chk("rx_out", inv2(data), rx_out);
      chk("tx_line_out", inv2(tx_in), tx_line_out);
      chk("tx_line_oe", 2'b11, tx_line_oe);
      chk("pumps", {rail_pos_low, rail_neg_low}, {pump_pos_en, pump_neg_en});
    end
    force_shutdown_n <= 1'b0;
    tick(6);
    chk("oe_forced", 2'b00, tx_line_oe);
    chk("power_forced", 3'b000, {pump_pos_en, pump_neg_en, supply_on});
    apb(1'b0, `REG_STATUS, 32'h0);
    chk("mode_forced", 2'd3, rd[1:0]);
    link_up <= 1'b0;
    tick(int'(MISS) - 4);
    chk("missing_early", 1'b1, missing_signal_n);
    tick(12);
    chk("missing_low", 1'b0, missing_signal_n);
    chk("rx_in_shutdown", 2'b11, rx_out);
    link_up <= 1'b1;
    tick(5);
    chk("missing_high", 1'b1, missing_signal_n);
    force_shutdown_n <= 1'b1;
    tick(int'(WAKE) + 1);
    chk("oe_waking", 2'b00, tx_line_oe);
    tick(6);
    chk("oe_woken", 2'b11, tx_line_oe);
    apb(1'b0, `REG_IRQ_STATUS, 32'h0);
    chk("irq_status", 32'he, rd);
    apb(1'b1, `REG_IRQ_STATUS, 32'hf);
    apb(1'b0, `REG_IRQ_STATUS, 32'h0);
    chk("irq_cleared", 32'h0, rd);
    force_active <= 1'b1;
    tick(int'(IDLE) + 20);
    chk("oe_forced_on", 2'b11, tx_line_oe);
    force_active <= 1'b0;
    tick(int'(IDLE) - 30);
    data <= ~data;
    tick(int'(IDLE) - 30);
    chk("oe_restarted", 2'b11, tx_line_oe);
    tick(int'(WAKE) + 60);
    chk("oe_auto_off", 2'b00, tx_line_oe);
    apb(1'b0, `REG_STATUS, 32'h0);
    chk("mode_auto", 2'd2, rd[1:0]);
    apb(1'b1, `REG_IRQ_MASK, 32'h1);
    tick(1);
    chk("irq_on", 1'b1, irq);
    apb(1'b1, `REG_IRQ_MASK, 32'h0);
    tick(1);
    chk("irq_masked", 1'b0, irq);
    apb(1'b1, `REG_IRQ_MASK, 32'h1);
    apb(1'b1, `REG_IRQ_STATUS, 32'h1);
    tick(1);
    chk("irq_w1c", 1'b0, irq);
    tx_in <= tx_in ^ 2'b01;
    tick(int'(WAKE) + 8);
    chk("oe_wake_edge", 2'b11, tx_line_oe);
    chk("tx_after_wake", inv2(tx_in), tx_line_out);
    // Both force inputs tied to one software line
    force_shutdown_n <= 1'b0;
    force_active <= 1'b0;
    tick(6);
    chk("oe_line_low", 2'b00, tx_line_oe);
    force_shutdown_n <= 1'b1;
    force_active <= 1'b1;
    tick(int'(IDLE) + int'(WAKE) + 20);
    chk("oe_line_high", 2'b11, tx_line_oe);
    chk("supply_line_high", 1'b1, supply_on);
    print_verdict();
  end
endmodule // rs232_line_power_mode_control_bench
`default_nettype wire
